// ### design/synth_div_pkg.sv
// Purpose: Shared constants for the serially programmed synthesiser dividers.
// Assumes: One 125 MHz clock; registers reached over APB with 32-bit data.
// Notes: Function

package synth_div_pkg;

    // -----------------------------------------------------------------
    // Field widths and frame layout
    // -----------------------------------------------------------------
    localparam int SWALLOW_W = 7;
    localparam int MAIN_W = 10;
    localparam int REF_W = 11;
    localparam int FRAME_W = 28;
    localparam int HEAD_W = 17;
    localparam int EDGE_W = 5;
    localparam logic [4:0] FULL_EDGES = 5'h1c;
    localparam logic [4:0] HEAD_EDGES = 5'h11;

    // -----------------------------------------------------------------
    // Reset values of the counter latches and the run bit
    // -----------------------------------------------------------------
    localparam logic [6:0] SWALLOW_RESET = 7'h00;
    localparam logic [9:0] MAIN_RESET = 10'h003;
    localparam logic [10:0] REF_RESET = 11'h003;
    localparam logic CTRL_RUN_RESET = 1'h1;

    // -----------------------------------------------------------------
    // Outside inputs, index in the synchroniser vectors
    // -----------------------------------------------------------------
    localparam int IN_W = 5;
    localparam int IN_DATA = 0;
    localparam int IN_SCLK = 1;
    localparam int IN_EN = 2;
    localparam int IN_FIN = 3;
    localparam int IN_OSC = 4;

    // -----------------------------------------------------------------
    // APB register map (byte addresses)
    // -----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SWALLOW_OFFSET = 8'h04;
    localparam logic [7:0] MAIN_OFFSET = 8'h08;
    localparam logic [7:0] REF_OFFSET = 8'h0c;
    localparam logic [7:0] STATUS_OFFSET = 8'h10;
    localparam int CTRL_RUN_BIT = 0;
    localparam int STATUS_EDGE_LSB = 0;
    localparam int STATUS_MOD_BIT = 8;
    localparam int STATUS_EN_BIT = 9;
    localparam int STATUS_HOLD_BIT = 10;

endpackage : synth_div_pkg

// ### design/synth_dividers.sv
// Purpose: Serial programming port, swallow/main/reference dividers, APB.
// Assumes: Serial, prescaler and oscillator inputs are asynchronous pins.
// Notes: Every pin passes three flops; a change counts when stages agree.
`timescale 1ns/10ps
`default_nettype none

module synth_dividers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_data,
    input wire logic serial_clock,
    input wire logic serial_enable,
    input wire logic prescaler_count_input,
    input wire logic osc_input,
    output logic prescaler_modulus_select,
    output logic main_divider_pulse,
    output logic ref_divider_pulse
);

    // -----------------------------------------------------------------
    // Operation overview
    // -----------------------------------------------------------------
    // Every pin input is sampled by pclk through three flip-flops.
    // A new pin level is accepted only when the second and third stages
    // agree and differ from the filtered level held in the state.
    // A pin must therefore stay put for at least two pclk cycles.
    // Shorter pulses on a pin are dropped without any trace.
    // The filtered levels give one-cycle rise and fall strobes.
    // These strobes drive the serial port and both dividers.
    //
    // The serial port shifts one bit on each accepted clock fall.
    // Bits are only taken while the filtered enable level is high.
    // A clock fall that lands in the same cycle as the enable fall is
    // dropped, so a frame cannot gain a stray bit at its very end.
    // The edge counter clears on the enable rise and saturates at the
    // full frame length, so it also reads back as a frame length.
    // The first seventeen bits are kept aside in a separate register.
    // A short frame thus still fills the swallow and main latches.
    // The reference latch only moves when a full frame was counted.
    // This shields the reference from glitches after a short update.
    //
    // The main chain counts accepted rises of the prescaler input.
    // The main counter reloads at its terminal count and pulses once.
    // The swallow counter runs down in the same cycle as the main one.
    // Modulus select stays low while the swallow counter is non-zero.
    // It rises once the swallow counter reaches zero and stays high.
    // It falls again only at the reload, together with the main pulse.
    // A swallow count of zero keeps modulus select high throughout.
    // The host must keep the main count above the swallow count.
    // Otherwise the swallow counter cannot finish inside one cycle.
    //
    // The reference chain counts accepted rises of the oscillator.
    // Its phase toggles every programmed count of oscillator rises.
    // It pulses on every second toggle, so the ratio is twice the count.
    // New latch values take effect at the main counter's terminal
    // count; a load restarts the running reference counter at that point.
    // This keeps lock times short for small frequency steps.
    //
    // A load also asks for the two pulse trains to be aligned again.
    // The reference chain then waits for the next main pulse and
    // restarts with it, so both pulses appear in the same cycle.
    // A new load request wins over a clear in that same cycle.
    //
    // The run bit freezes all counters but not the serial port.
    // Loads taken while frozen are kept and applied after restart.
    //
    // The register port is a zero-wait slave with one-cycle access.
    // Read data is taken in the setup cycle and held until the next.
    // Unmapped addresses answer with an error and read as zero.
    // Only the control word can be written; the latches are read-only.
    //
    // Hazards for a user of this block:
    // The prescaler and oscillator inputs must stay well below a quarter
    // of the pclk rate, or the synchronisers lose edges.
    // The serial clock phases must each last at least two pclk cycles.
    // Enable must only move while the serial clock stands high.
    // Fast pin rates were traded for a single clock domain here.

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] level;
        logic [27:0] shift;
        logic [16:0] head;
        logic [4:0] edges;
        logic [6:0] swallow_lat;
        logic [9:0] main_lat;
        logic [10:0] ref_lat;
        logic [6:0] a_cnt;
        logic [9:0] m_cnt;
        logic [10:0] r_cnt;
        logic ref_phase;
        logic ref_hold;
        logic mod_sel;
        logic main_pulse;
        logic ref_pulse;
        logic run;
        logic [31:0] rdata;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic [4:0] rise;
    logic [4:0] fall;
    logic [4:0] changed;
    logic mapped;

    // Register read multiplexer, shared by the read path.
    function automatic logic [31:0] read_word(input state_type s,
                                              input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h00000000;
        unique case (addr)
            synth_div_pkg::CTRL_OFFSET: begin
                w[synth_div_pkg::CTRL_RUN_BIT] = s.run;
            end
            synth_div_pkg::SWALLOW_OFFSET: begin
                w[6:0] = s.swallow_lat;
            end
            synth_div_pkg::MAIN_OFFSET: begin
                w[9:0] = s.main_lat;
            end
            synth_div_pkg::REF_OFFSET: begin
                w[10:0] = s.ref_lat;
            end
            synth_div_pkg::STATUS_OFFSET: begin
                w[synth_div_pkg::STATUS_EDGE_LSB +: 5] = s.edges;
                w[synth_div_pkg::STATUS_MOD_BIT] = s.mod_sel;
                w[synth_div_pkg::STATUS_EN_BIT] =
                    s.level[synth_div_pkg::IN_EN];
                w[synth_div_pkg::STATUS_HOLD_BIT] = s.ref_hold;
            end
            default: begin
                w = 32'h00000000;
            end
        endcase
        return w;
    endfunction : read_word

    // Counter step: decrement, never below zero.
    function automatic logic [10:0] step_down(input logic [10:0] v);
        return (v == 11'h000) ? 11'h000 : v - 11'h001;
    endfunction : step_down

    // -----------------------------------------------------------------
    // Edge detection on filtered pin levels
    // -----------------------------------------------------------------

    // A change is accepted once the second and third stages agree.
    always_comb begin
        changed = (st_r.sync2 ~^ st_r.sync3) & (st_r.sync3 ^ st_r.level);
        rise = changed & st_r.sync3;
        fall = changed & ~st_r.sync3;
    end

    // Address decode for the APB slave.
    always_comb begin
        mapped = (paddr == synth_div_pkg::CTRL_OFFSET) ||
                 (paddr == synth_div_pkg::SWALLOW_OFFSET) ||
                 (paddr == synth_div_pkg::MAIN_OFFSET) ||
                 (paddr == synth_div_pkg::REF_OFFSET) ||
                 (paddr == synth_div_pkg::STATUS_OFFSET);
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------

    // All serial, divider and bus behaviour in one combinational pass.
    always_comb begin
        logic en_level;
        logic data_bit;
        logic [6:0] a_next;
        logic [10:0] a_wide;
        en_level = 1'b0;
        data_bit = 1'b0;
        a_next = 7'h00;
        a_wide = 11'h000;
        st_nxt = st_r;
        st_nxt.main_pulse = 1'b0;
        st_nxt.ref_pulse = 1'b0;

        // Three-stage pin synchronisers and filtered levels.
        st_nxt.sync1 = {osc_input, prescaler_count_input, serial_enable,
                        serial_clock, serial_data};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.level = st_r.level ^ changed;

        en_level = st_r.level[synth_div_pkg::IN_EN];
        data_bit = st_r.sync3[synth_div_pkg::IN_DATA];

        if (rise[synth_div_pkg::IN_EN]) begin
            st_nxt.edges = 5'h00;
        end

        // enable moves only while serial clock is high
        if (en_level && fall[synth_div_pkg::IN_SCLK] &&
            !fall[synth_div_pkg::IN_EN]) begin
            st_nxt.shift = {st_r.shift[26:0], data_bit};
            if (st_r.edges < synth_div_pkg::HEAD_EDGES) begin
                st_nxt.head = {st_r.head[15:0], data_bit};
            end
            if (st_r.edges != synth_div_pkg::FULL_EDGES) begin
                st_nxt.edges = st_r.edges + 5'h01;
            end
        end

        if (fall[synth_div_pkg::IN_EN]) begin
            st_nxt.swallow_lat = st_r.head[16:10];
            st_nxt.main_lat = st_r.head[9:0];
            if (st_r.edges >= synth_div_pkg::FULL_EDGES) begin
                st_nxt.ref_lat = st_r.shift[10:0];
            end
            st_nxt.ref_hold = 1'b1;
        end

        // Main chain: swallow and main counters on prescaler edges.
        if (st_r.run && rise[synth_div_pkg::IN_FIN]) begin
            if (st_r.m_cnt <= 10'h001) begin
                st_nxt.m_cnt = st_r.main_lat;
                st_nxt.a_cnt = st_r.swallow_lat;
                st_nxt.mod_sel = (st_r.swallow_lat == 7'h00);
                st_nxt.main_pulse = 1'b1;
            end else begin
                st_nxt.m_cnt = st_r.m_cnt - 10'h001;
                a_wide = step_down({4'h0, st_r.a_cnt});
                a_next = a_wide[6:0];
                st_nxt.a_cnt = a_next;
                st_nxt.mod_sel = (a_next == 7'h00);
            end
        end

        // Reference chain: halves of R oscillator edges, pulse per 2R.
        if (st_r.run && st_r.ref_hold) begin
            if (st_nxt.main_pulse) begin
                // A load in this very cycle keeps the hold request.
                st_nxt.ref_hold = fall[synth_div_pkg::IN_EN];
                st_nxt.r_cnt = st_r.ref_lat;
                st_nxt.ref_phase = 1'b1;
                st_nxt.ref_pulse = 1'b1;
            end
        end else if (st_r.run && rise[synth_div_pkg::IN_OSC]) begin
            if (st_r.r_cnt <= 11'h001) begin
                st_nxt.r_cnt = st_r.ref_lat;
                st_nxt.ref_phase = ~st_r.ref_phase;
                st_nxt.ref_pulse = ~st_r.ref_phase;
            end else begin
                st_nxt.r_cnt = step_down(st_r.r_cnt);
            end
        end

        // APB: read data captured in setup, write taken in access.
        if (psel && !penable) begin
            st_nxt.rdata = read_word(st_r, paddr);
        end
        if (psel && penable && pwrite &&
            (paddr == synth_div_pkg::CTRL_OFFSET)) begin
            st_nxt.run = pwdata[synth_div_pkg::CTRL_RUN_BIT];
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------

    // Asynchronous reset to constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{sync1: 5'h00, sync2: 5'h00, sync3: 5'h00,
                      level: 5'h00, shift: 28'h0000000, head: 17'h00000,
                      edges: 5'h00,
                      swallow_lat: synth_div_pkg::SWALLOW_RESET,
                      main_lat: synth_div_pkg::MAIN_RESET,
                      ref_lat: synth_div_pkg::REF_RESET,
                      a_cnt: synth_div_pkg::SWALLOW_RESET,
                      m_cnt: synth_div_pkg::MAIN_RESET,
                      r_cnt: synth_div_pkg::REF_RESET,
                      ref_phase: 1'b0, ref_hold: 1'b0, mod_sel: 1'b0,
                      main_pulse: 1'b0, ref_pulse: 1'b0,
                      run: synth_div_pkg::CTRL_RUN_RESET,
                      rdata: 32'h00000000};
        end else begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------

    // Zero-wait slave; unmapped addresses answer with an error.
    always_comb begin
        pready = 1'b1;
        pslverr = psel && penable && !mapped;
        prdata = st_r.rdata;
    end

    always_comb begin
        prescaler_modulus_select = st_r.mod_sel;
        main_divider_pulse = st_r.main_pulse;
        ref_divider_pulse = st_r.ref_pulse;
    end

endmodule : synth_dividers

`default_nettype wire

// ### tb/serial_host_model.sv
// Purpose: Host side of the three-wire programming port.
// Assumes: Serial clock idles high and stands still between frames except during noise.
// Notes: Low phase lasts 40 ns, high phase 80 ns, so a link clock period is 120 ns.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
    output logic serial_data,
    output logic serial_clock,
    output logic serial_enable
);
    // Idle pins; the clock rests high.
    initial begin
        serial_data = 1'b0;
        serial_clock = 1'b1;
        serial_enable = 1'b0;
    end
    // frame, MSB first, enable moved while clock high.
    task automatic send(input logic [27:0] w, input int n);
        serial_enable = 1'b1;
        for (int i = 0; i < n; i++) begin
            #40 serial_data = w[27 - i];
            #40 serial_clock = 1'b0;
            #40 serial_clock = 1'b1;
        end
        #40 serial_enable = 1'b0;
        #40 serial_data = ~serial_data; // Released data no longer holds.
    endtask : send
    // Clock and data wiggle while enable is low.
    task automatic noise();
        repeat (4) begin
            #40 serial_clock = 1'b0;
            serial_data = ~serial_data;
            #40 serial_clock = 1'b1;
        end
    endtask : noise
endmodule : serial_host_model
`default_nettype wire

// ### tb/synth_div_chk_sva.sv
// Purpose: Port checks of the synthesiser dividers.
// Assumes: Bound into every synth_dividers instance.
// Notes: Pin ages count pclk cycles since that pin last moved.
`timescale 1ns/10ps
`default_nettype none
module synth_div_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic prescaler_count_input,
    input wire logic osc_input,
    input wire logic prescaler_modulus_select,
    input wire logic main_divider_pulse,
    input wire logic ref_divider_pulse
);
    logic fin_q_r, osc_q_r;
    logic [4:0] fin_age_r, osc_age_r;
    wire logic acc = psel && penable;
    wire logic mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
    // Ages saturate so that a pulse long after a pin edge is caught.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fin_q_r <= 1'b0;
            osc_q_r <= 1'b0;
            fin_age_r <= 5'h1f;
            osc_age_r <= 5'h1f;
        end else begin
            fin_q_r <= prescaler_count_input;
            osc_q_r <= osc_input;
            fin_age_r <= (prescaler_count_input != fin_q_r) ? 5'h00 :
                fin_age_r + {4'h0, fin_age_r != 5'h1f};
            osc_age_r <= (osc_input != osc_q_r) ? 5'h00 :
                osc_age_r + {4'h0, osc_age_r != 5'h1f};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_main_one_cycle: assert property (main_divider_pulse |=> !main_divider_pulse)
        else $error("main pulse wider than one cycle");
    a_ref_one_cycle: assert property (ref_divider_pulse |=> !ref_divider_pulse)
        else $error("reference pulse wider than one cycle");
    a_mod_on_fin: assert property ($changed(prescaler_modulus_select) |-> fin_age_r <= 5'h0c)
        else $error("modulus select moved without a prescaler edge");
    a_main_on_fin: assert property (main_divider_pulse |-> fin_age_r <= 5'h0c)
        else $error("main pulse without a prescaler edge");
    a_ref_source: assert property (ref_divider_pulse |-> osc_age_r <= 5'h0c || main_divider_pulse)
        else $error("reference pulse from no cause");
    a_mod_fall_start: assert property ($fell(prescaler_modulus_select) |-> main_divider_pulse)
        else $error("modulus select fell inside a cycle");
    a_err_map: assert property (acc |-> pslverr == !mapped)
        else $error("slave error does not match the map");
    a_ready_now: assert property (psel && !penable |=> pready)
        else $error("access phase not answered");
    a_err_zero: assert property (acc && !mapped |-> prdata == 32'h0)
        else $error("unmapped read gave data");
endmodule : synth_div_chk
bind synth_dividers synth_div_chk u_chk (.*);
`default_nettype wire

// ### tb/synth_dividers_tb.sv
// Purpose: Self-checking bench for the synthesiser dividers.
// Assumes: Prescaler period 80 ns, oscillator period 64 ns.
// Notes: Divider spans are counted in pclk cycles at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module synth_dividers_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, er, serial_data, serial_clock, serial_enable;
    logic prescaler_count_input = 1'b0, osc_input = 1'b0;
    logic prescaler_modulus_select, main_divider_pulse, ref_divider_pulse;
    logic [31:0] rst_exp [4] = '{32'h1, 32'h0, 32'h3, 32'h3};
    int n_fail = 0, cmp_count = 0, c, h, n;
    synth_dividers DUT (.*);
    serial_host_model host (.*);
    // Clock and the two free-running divider inputs.
    initial begin
        forever #4 pclk = ~pclk;
    end
    always begin
        repeat (5) @(posedge pclk);
        prescaler_count_input <= ~prescaler_count_input;
    end
    always begin
        repeat (4) @(posedge pclk);
        osc_input <= ~osc_input;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; read data and error taken at the ready edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Send a frame, then read the three latches and the edge count.
    task automatic load(input logic [27:0] w, input int b,
                        input logic [10:0] rx, input logic [4:0] ed);
        host.send(w, b);
        repeat (10) @(posedge pclk);
        apb(0, 8'h04, 0);
        chk(rv, {25'h0, w[27:21]});
        apb(0, 8'h08, 0);
        chk(rv, {22'h0, w[20:11]});
        apb(0, 8'h0c, 0);
        chk(rv, {21'h0, rx});
        apb(0, 8'h10, 0);
        chk({27'h0, rv[4:0]}, {27'h0, ed});
    endtask : load
    // Cycles between two pulses, and modulus-high cycles among them.
    task automatic span(input logic s);
        c = 0;
        h = 0;
        n = 0;
        while ((s ? ref_divider_pulse : main_divider_pulse) !== 1'b1 && n++ < 2000)
            @(negedge pclk);
        do begin
            @(negedge pclk);
            c++;
            h += prescaler_modulus_select;
        end while ((s ? ref_divider_pulse : main_divider_pulse) !== 1'b1 && c < 2000);
    endtask : span
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    // Watchdog well beyond the length of all tests.
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), 0);
            chk(rv, rst_exp[i]);
        end
        apb(1, 8'h20, 32'hff);
        chk({31'h0, er}, 32'h1);
        apb(1, 8'h08, 32'h3ff);
        apb(0, 8'h08, 0);
        chk(rv, 32'h3);
        $display("test registers done");
        load({7'h7f, 10'h3ff, 11'h7ff}, 28, 11'h7ff, 5'h1c);
        load({7'h01, 10'h006, 11'h155}, 17, 11'h7ff, 5'h11);
        host.noise();
        apb(0, 8'h10, 0);
        chk({27'h0, rv[4:0]}, 32'h11);
        load({7'h02, 10'h005, 11'h004}, 28, 11'h004, 5'h1c);
        $display("test serial loads done");
        apb(1, 8'h00, 32'h0);
        host.send({7'h02, 10'h005, 11'h004}, 28);
        apb(0, 8'h10, 0);
        chk({31'h0, rv[10]}, 32'h1);
        apb(1, 8'h00, 32'h1);
        n = 0;
        while (main_divider_pulse !== 1'b1 && n++ < 15000)
            @(negedge pclk);
        chk({31'h0, main_divider_pulse}, 32'h1);
        chk({31'h0, ref_divider_pulse}, 32'h1);
        span(1'b0);
        chk(c, 50);
        chk(h, 30);
        span(1'b1);
        chk(c, 64);
        $display("test dividers done");
        conclude();
    end
endmodule : synth_dividers_tb
`default_nettype wire
